// ### design/dcis_map.svh
`ifndef DCIS_MAP_SVH
`define DCIS_MAP_SVH

// ----------------------------------------------------------------
// register offsets inside the board i/o region
// ----------------------------------------------------------------
`define DCIS_ADDR_W 5
`define DCIS_OFS_CTR_LOW 5'h10
`define DCIS_OFS_CTR_HIGH 5'h11
`define DCIS_OFS_CTR_MODE 5'h13
`define DCIS_OFS_PORT_EN 5'h14
`define DCIS_OFS_CTR_IRQ 5'h15

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCIS_CW_SEL 7:6
`define DCIS_CW_RW 5:4
`define DCIS_CW_MODE 3:1
`define DCIS_CTL_MASTER 2
`define DCIS_CTL_CTR_EN 1
`define DCIS_CTL_SRC 0
`define DCIS_CTL_W 3
`define DCIS_SEL_CTR_LOW 2'h0
`define DCIS_SEL_CTR_HIGH 2'h1

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define DCIS_BYTE_RESET 8'h00
`define DCIS_CTL_RESET 3'h0
`define DCIS_CLK_HZ 50_000_000
`define DCIS_XTAL_HZ 16_000_000
`define DCIS_XTAL_DIV 8
`define DCIS_CNT_W 16
`define DCIS_BYTE_W 8
`define DCIS_GROUPS 4

`endif

// ### design/dcis_pkg.sv
package dcis_pkg;
    // counter operating modes, after folding the two alias codes
    typedef enum logic [2:0] {
        DCIS_M_TERM = 3'b000,
        DCIS_M_ONESHOT = 3'b001,
        DCIS_M_RATE = 3'b010,
        DCIS_M_SQUARE = 3'b011,
        DCIS_M_SWSTB = 3'b100,
        DCIS_M_HWSTB = 3'b101
    } dcis_mode_e;

    // byte access order of a counter data register
    typedef enum logic [1:0] {
        DCIS_RW_LATCH = 2'b00,
        DCIS_RW_LSB = 2'b01,
        DCIS_RW_MSB = 2'b10,
        DCIS_RW_BOTH = 2'b11
    } dcis_rw_e;
endpackage

// ### design/dcis_tick.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

module dcis_tick #(
    parameter int PERIOD = 25
) (
    input wire logic clock,
    input wire logic rstn,
    output logic tick
);
    localparam int W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
    localparam logic [W-1:0] LAST = W'(PERIOD - 1);

    if (PERIOD < 1) begin : g_bad_period
        $error("dcis_tick period must be at least one cycle");
    end

    logic [W-1:0] cnt_reg;
    logic tick_reg;
    wire logic at_last = (cnt_reg == LAST);

    // free running divider, one pulse per period
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= at_last ? '0 : cnt_reg + W'(1);
            tick_reg <= at_last;
        end
    end

    assign tick = tick_reg;
endmodule

// ### design/dcis_counter.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

module dcis_counter #(
    parameter int CNT_W = `DCIS_CNT_W
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic tick,
    input wire logic mode_stb,
    input wire logic [2:0] mode_in,
    input wire logic load_stb,
    input wire logic [CNT_W-1:0] load_val,
    output logic [CNT_W-1:0] count,
    output logic out
);
    if (CNT_W < 2) begin : g_bad_width
        $error("dcis_counter needs at least two bits");
    end

    dcis_pkg::dcis_mode_e mode_reg;
    logic [CNT_W-1:0] reload_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic out_reg;
    logic out_next;
    logic pend_reg;
    logic armed_reg;
    logic done_reg;
    logic done_next;

    wire logic is_one = (count_reg == CNT_W'(1));
    wire logic is_two = (count_reg == CNT_W'(2));
    wire logic is_term = (mode_in == dcis_pkg::DCIS_M_TERM);

    // next count and output per mode; zero counts as full range
    always_comb begin
        count_next = count_reg - CNT_W'(1);
        out_next = out_reg;
        done_next = done_reg;
        unique case (mode_reg)
            dcis_pkg::DCIS_M_TERM,
            dcis_pkg::DCIS_M_ONESHOT: begin
                if (is_one) begin
                    out_next = 1'b1;
                end
            end
            dcis_pkg::DCIS_M_RATE: begin
                out_next = !is_two;
                if (is_one) begin
                    count_next = reload_reg;
                end
            end
            dcis_pkg::DCIS_M_SQUARE: begin
                count_next = count_reg - CNT_W'(2);
                if (is_one || is_two) begin
                    count_next = reload_reg;
                    out_next = !out_reg;
                end
            end
            dcis_pkg::DCIS_M_SWSTB,
            dcis_pkg::DCIS_M_HWSTB: begin
                // single low strobe at terminal count, then stays high
                out_next = !(is_one && !done_reg);
                done_next = done_reg || is_one;
            end
            default: begin
                out_next = out_reg;
            end
        endcase
    end

    // mode word stops the counter; a new count loads on the next tick
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_reg <= dcis_pkg::DCIS_M_TERM;
            reload_reg <= '0;
            count_reg <= '0;
            out_reg <= 1'b0;
            pend_reg <= 1'b0;
            armed_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (mode_stb) begin
            mode_reg <= dcis_pkg::dcis_mode_e'(mode_in);
            out_reg <= !is_term;
            pend_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (load_stb) begin
            reload_reg <= load_val;
            pend_reg <= 1'b1;
            if (mode_reg == dcis_pkg::DCIS_M_TERM) begin
                out_reg <= 1'b0;
            end
        end else if (tick && pend_reg) begin
            count_reg <= reload_reg;
            pend_reg <= 1'b0;
            armed_reg <= 1'b1;
            done_reg <= 1'b0;
        end else if (tick && armed_reg) begin
            count_reg <= count_next;
            out_reg <= out_next;
            done_reg <= done_next;
        end
    end

    assign count = count_reg;
    assign out = out_reg;
endmodule

// ### design/dcis_top.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

module dcis_top #(
    parameter int CLK_HZ = `DCIS_CLK_HZ,
    parameter int XTAL_HZ = `DCIS_XTAL_HZ,
    parameter int XTAL_DIV = `DCIS_XTAL_DIV
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`DCIS_ADDR_W-1:0] reg_addr,
    input wire logic [`DCIS_BYTE_W-1:0] reg_wdata,
    output logic [`DCIS_BYTE_W-1:0] reg_rdata,
    input wire logic [`DCIS_GROUPS-1:0] port_a_side_request,
    input wire logic [`DCIS_GROUPS-1:0] port_b_side_request,
    input wire logic [`DCIS_GROUPS-1:0] group_handshake_mode,
    input wire logic inta_n_i,
    output logic inta_n_o,
    output logic inta_n_oe
);
    // ----------------------------------------------------------------
    // sizes and elaboration checks
    // ----------------------------------------------------------------
    localparam int BW = `DCIS_BYTE_W;
    localparam int CW = `DCIS_CNT_W;
    localparam int NG = `DCIS_GROUPS;
    localparam int NCTR = 2;
    localparam int CTR_HZ = XTAL_HZ / XTAL_DIV;
    localparam int TICK_CYC = CLK_HZ / CTR_HZ;

    // the prescaled crystal must be at most half the system clock
    if (XTAL_DIV < 1 || CTR_HZ < 1 || TICK_CYC < 2) begin : g_bad_clk
        $error("dcis_top counter clock too fast for system clock");
    end
    if (CW != 2 * BW || 2 * NG != BW) begin : g_bad_width
        $error("dcis_top widths do not fit byte registers");
    end

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    // the bus is a plain byte port; reads answer one edge later
    wire logic acc_wr = reg_sel && reg_wr;
    wire logic acc_rd = reg_sel && reg_rd && !reg_wr;
    wire logic hit_mode = (reg_addr == `DCIS_OFS_CTR_MODE);
    wire logic hit_port = (reg_addr == `DCIS_OFS_PORT_EN);
    wire logic hit_ctl = (reg_addr == `DCIS_OFS_CTR_IRQ);
    wire logic wr_mode = acc_wr && hit_mode;
    wire logic wr_port = acc_wr && hit_port;
    wire logic wr_ctl = acc_wr && hit_ctl;

    // mode word fields as written
    wire logic [1:0] cw_sel = reg_wdata[`DCIS_CW_SEL];
    wire logic [1:0] cw_rw = reg_wdata[`DCIS_CW_RW];
    wire logic [2:0] cw_mode_raw = reg_wdata[`DCIS_CW_MODE];
    // codes x10 and x11 are aliases of rate and square wave
    wire logic [2:0] cw_mode = cw_mode_raw[1] ?
        {1'b0, cw_mode_raw[1:0]} : cw_mode_raw;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [BW-1:0] port_en_reg;
    logic [`DCIS_CTL_W-1:0] ctl_reg;
    logic [BW-1:0] mode_last_reg;
    logic [BW-1:0] rdata_reg;
    logic irq_reg;
    logic out0_d_reg;

    // software writes; upper control bits are dropped
    always_ff @(posedge clock) begin
        if (!rstn) begin
            port_en_reg <= `DCIS_BYTE_RESET;
            ctl_reg <= `DCIS_CTL_RESET;
            mode_last_reg <= `DCIS_BYTE_RESET;
        end else begin
            if (wr_port) begin
                port_en_reg <= reg_wdata;
            end
            if (wr_ctl) begin
                ctl_reg <= reg_wdata[`DCIS_CTL_W-1:0];
            end
            if (wr_mode) begin
                mode_last_reg <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // counter clocking
    // ----------------------------------------------------------------
    logic [NCTR-1:0] ctr_tick;
    logic [NCTR-1:0] ctr_out;
    logic [CW-1:0] ctr_count [NCTR];
    logic [BW-1:0] ctr_rd_byte [NCTR];
    logic [NCTR-1:0] ctr_rd_hit;

    // crystal over eight, rebuilt as a tick of the system clock
    dcis_tick #(
        .PERIOD(TICK_CYC)
    ) u_tick (
        .clock(clock),
        .rstn(rstn),
        .tick(ctr_tick[0])
    );

    // counter two counts rising edges of counter one's output;
    // gates are permanently active, so there is no gate input
    always_ff @(posedge clock) begin
        if (!rstn) begin
            out0_d_reg <= 1'b0;
        end else begin
            out0_d_reg <= ctr_out[0];
        end
    end
    assign ctr_tick[1] = ctr_out[0] && !out0_d_reg;

    // ----------------------------------------------------------------
    // per counter byte sequencing and count core
    // ----------------------------------------------------------------
    // index 0 is the lower half, index 1 the upper half
    for (genvar g = 0; g < NCTR; g++) begin : g_ctr
        localparam logic [`DCIS_ADDR_W-1:0] OFS = (g == 0) ?
            `DCIS_OFS_CTR_LOW : `DCIS_OFS_CTR_HIGH;
        localparam logic [1:0] SEL = (g == 0) ?
            `DCIS_SEL_CTR_LOW : `DCIS_SEL_CTR_HIGH;

        dcis_pkg::dcis_rw_e rw_reg;
        logic [BW-1:0] low_hold_reg;
        logic wr_hi_reg;
        logic rd_hi_reg;
        logic latch_on_reg;
        logic [CW-1:0] latch_val_reg;

        // a mode word for this counter, or a latch command
        wire logic cw_hit = wr_mode && (cw_sel == SEL);
        wire logic latch_cmd = cw_hit &&
            (cw_rw == dcis_pkg::DCIS_RW_LATCH);
        wire logic mode_cmd = cw_hit && !latch_cmd;
        wire logic data_wr = acc_wr && (reg_addr == OFS);
        wire logic data_rd = acc_rd && (reg_addr == OFS);
        wire logic rw_both = (rw_reg == dcis_pkg::DCIS_RW_BOTH);
        wire logic rw_msb = (rw_reg == dcis_pkg::DCIS_RW_MSB);

        // in two-byte order the first write only parks the low byte
        wire logic load_stb = data_wr && (!rw_both || wr_hi_reg);
        wire logic [CW-1:0] load_val = rw_both ?
            {reg_wdata, low_hold_reg} :
            (rw_msb ? {reg_wdata, `DCIS_BYTE_RESET} :
            {`DCIS_BYTE_RESET, reg_wdata});

        // reads see a latched snapshot when one is held
        wire logic [CW-1:0] rd_src = latch_on_reg ?
            latch_val_reg : ctr_count[g];
        wire logic rd_upper = rw_msb || (rw_both && rd_hi_reg);
        wire logic rd_last = data_rd && (!rw_both || rd_hi_reg);

        assign ctr_rd_byte[g] = rd_upper ?
            rd_src[CW-1:BW] : rd_src[BW-1:0];
        assign ctr_rd_hit[g] = data_rd;

        // a mode word restarts both byte flip-flops; count bytes
        // written before it are lost, hence mode word comes first
        always_ff @(posedge clock) begin
            if (!rstn) begin
                rw_reg <= dcis_pkg::DCIS_RW_BOTH;
                low_hold_reg <= `DCIS_BYTE_RESET;
                wr_hi_reg <= 1'b0;
                rd_hi_reg <= 1'b0;
                latch_on_reg <= 1'b0;
                latch_val_reg <= '0;
            end else if (mode_cmd) begin
                rw_reg <= dcis_pkg::dcis_rw_e'(cw_rw);
                wr_hi_reg <= 1'b0;
                rd_hi_reg <= 1'b0;
                latch_on_reg <= 1'b0;
            end else begin
                if (data_wr) begin
                    low_hold_reg <= reg_wdata;
                    wr_hi_reg <= rw_both && !wr_hi_reg;
                end
                if (data_rd) begin
                    rd_hi_reg <= rw_both && !rd_hi_reg;
                end
                // a second latch command is ignored until read out
                if (latch_cmd && !latch_on_reg) begin
                    latch_on_reg <= 1'b1;
                    latch_val_reg <= ctr_count[g];
                end else if (rd_last) begin
                    latch_on_reg <= 1'b0;
                end
            end
        end

        dcis_counter #(
            .CNT_W(CW)
        ) u_counter (
            .clock(clock),
            .rstn(rstn),
            .tick(ctr_tick[g]),
            .mode_stb(mode_cmd),
            .mode_in(cw_mode),
            .load_stb(load_stb),
            .load_val(load_val),
            .count(ctr_count[g]),
            .out(ctr_out[g])
        );
    end
    // mode words naming the third counter or read-back fall through
    // the select compare above and only update the mode byte read back

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    wire logic [BW-1:0] ctl_view = {
        {(BW - `DCIS_CTL_W){1'b0}}, ctl_reg};
    wire logic [BW-1:0] rd_mux =
        ctr_rd_hit[0] ? ctr_rd_byte[0] :
        ctr_rd_hit[1] ? ctr_rd_byte[1] :
        hit_mode ? mode_last_reg :
        hit_port ? port_en_reg :
        hit_ctl ? ctl_view :
        `DCIS_BYTE_RESET;

    // the data bus holds the last read until the next read
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_reg <= `DCIS_BYTE_RESET;
        end else if (acc_rd) begin
            rdata_reg <= rd_mux;
        end
    end
    assign reg_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // interrupt combination
    // ----------------------------------------------------------------
    // even enable bits serve the a side, odd bits the b side
    logic [BW-1:0] port_req;
    for (genvar p = 0; p < NG; p++) begin : g_port
        assign port_req[2*p] = port_a_side_request[p] &&
            group_handshake_mode[p];
        assign port_req[2*p+1] = port_b_side_request[p] &&
            group_handshake_mode[p];
    end

    wire logic port_any = |(port_req & port_en_reg);
    // a single select bit makes the two counter sources exclusive
    wire logic ctr_src = ctl_reg[`DCIS_CTL_SRC] ?
        ctr_out[1] : ctr_out[0];
    wire logic ctr_any = ctl_reg[`DCIS_CTL_CTR_EN] && ctr_src;
    wire logic irq_next = ctl_reg[`DCIS_CTL_MASTER] &&
        (port_any || ctr_any);

    // registered so the pin never glitches on decode changes
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // open drain: pull low while requesting, release otherwise;
    // the pin level coming back is not needed by this block
    assign inta_n_o = 1'b0;
    assign inta_n_oe = irq_reg;
endmodule

// ### verification/dcis_top_assertions.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

// ----------------------------------------------------------------
// interrupt pin and register checks at the top ports
// ----------------------------------------------------------------
module dcis_top_checker (
    input wire logic clock,
    input wire logic rstn,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`DCIS_ADDR_W-1:0] reg_addr,
    input wire logic [`DCIS_BYTE_W-1:0] reg_wdata,
    input wire logic [`DCIS_BYTE_W-1:0] reg_rdata,
    input wire logic [`DCIS_GROUPS-1:0] port_a_side_request,
    input wire logic [`DCIS_GROUPS-1:0] port_b_side_request,
    input wire logic [`DCIS_GROUPS-1:0] group_handshake_mode,
    input wire logic inta_n_i,
    input wire logic inta_n_o,
    input wire logic inta_n_oe
);
    logic [7:0] en_reg;
    logic [2:0] ctl_reg;
    logic [7:0] live;
    logic wr_hit;
    logic rd_hit;
    logic port_hit;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // even bit is the a side of a group, odd bit the b side
    assign wr_hit = reg_sel && reg_wr;
    assign rd_hit = reg_sel && reg_rd && !reg_wr;
    for (genvar g = 0; g < `DCIS_GROUPS; g++) begin : g_live
        assign live[2*g] = port_a_side_request[g] & group_handshake_mode[g];
        assign live[2*g+1] = port_b_side_request[g] & group_handshake_mode[g];
    end
    assign port_hit = ctl_reg[2] && |(live & en_reg);

    // shadow of the enables, rebuilt from bus writes only
    always_ff @(posedge clock) begin
        if (!rstn) begin
            en_reg <= 8'h00;
            ctl_reg <= 3'h0;
        end else if (wr_hit && reg_addr == `DCIS_OFS_PORT_EN) begin
            en_reg <= reg_wdata;
        end else if (wr_hit && reg_addr == `DCIS_OFS_CTR_IRQ) begin
            ctl_reg <= reg_wdata[2:0];
        end
    end

    chk_master_blocks: assert property (
        !ctl_reg[2] |=> !inta_n_oe) else $error("pin low without master");
    chk_port_raises: assert property (
        port_hit |=> inta_n_oe) else $error("enabled request not seen");
    chk_grp3b_raise: assert property (
        ctl_reg[2] && en_reg[7] && live[7] |=> inta_n_oe)
        else $error("group three b request not seen");
    chk_no_source: assert property (
        !ctl_reg[1] && !(|(live & en_reg)) |=> !inta_n_oe)
        else $error("pin low with no source");
    chk_mode_gate: assert property (
        !ctl_reg[1] && group_handshake_mode == 4'h0 |=> !inta_n_oe)
        else $error("request passed outside handshake mode");
    chk_drive_low: assert property (
        inta_n_oe |-> inta_n_o == 1'b0) else $error("pin driven high");
    chk_ctl_read: assert property (
        rd_hit && reg_addr == `DCIS_OFS_CTR_IRQ |=>
        reg_rdata == {5'h00, ctl_reg}) else $error("control read wrong");
    chk_en_read: assert property (
        rd_hit && reg_addr == `DCIS_OFS_PORT_EN |=> reg_rdata == en_reg)
        else $error("enable read wrong");
    chk_gap_zero: assert property (
        rd_hit && reg_addr == 5'h12 |=> reg_rdata == 8'h00)
        else $error("unused offset read not zero");

    cover property (port_hit ##1 inta_n_oe);
    cover property (ctl_reg[1] && ctl_reg[0] ##1 inta_n_oe);
    cover property (rd_hit && reg_addr == `DCIS_OFS_CTR_IRQ);
endmodule

bind dcis_top dcis_top_checker chk (
    .clock, .rstn, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .port_a_side_request, .port_b_side_request,
    .group_handshake_mode, .inta_n_i, .inta_n_o, .inta_n_oe
);

// ### verification/dcis_host_model.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

// ----------------------------------------------------------------
// host side of the bridge: byte wide register cycles
// ----------------------------------------------------------------
module dcis_host_model (
    input wire logic clock,
    output logic reg_sel,
    output logic reg_wr,
    output logic reg_rd,
    output logic [`DCIS_ADDR_W-1:0] reg_addr,
    output logic [`DCIS_BYTE_W-1:0] reg_wdata
);
    initial begin
        reg_sel = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
    end

    // released lines show the inverse, so a stale value never matches
    task automatic cycle(input logic wr, input logic [4:0] addr,
                         input logic [7:0] data);
        @(posedge clock);
        reg_sel <= 1'b1;
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clock);
        reg_sel <= 1'b0;
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~addr;
        reg_wdata <= ~data;
    endtask

    // mode word first, then the count as low byte and high byte
    task automatic load_ctr(input logic sel, input logic [2:0] mode,
                            input logic [15:0] val);
        logic [4:0] a;
        a = sel ? `DCIS_OFS_CTR_HIGH : `DCIS_OFS_CTR_LOW;
        cycle(1'b1, `DCIS_OFS_CTR_MODE,
              {1'b0, sel, 2'b11, mode, 1'b0});
        cycle(1'b1, a, val[7:0]);
        cycle(1'b1, a, val[15:8]);
    endtask
endmodule

// ### verification/dio_counter_interrupt_select_test.sv
`timescale 1ns/1ps
`include "dcis_map.svh"

// ----------------------------------------------------------------
// bench: register bus, port requests and counter timing
// ----------------------------------------------------------------
module dio_counter_interrupt_select_test;
    // two clocks per counter tick keeps the counter runs short
    localparam int CLK_HZ = 50_000_000;
    localparam int XTAL_HZ = 25_000_000;
    localparam int XTAL_DIV = 1;
    localparam int TICK = CLK_HZ / (XTAL_HZ / XTAL_DIV);
    logic clock;
    logic rstn;
    logic reg_sel;
    logic reg_wr;
    logic reg_rd;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [3:0] a_req;
    logic [3:0] b_req;
    logic [3:0] hs_mode;
    logic inta_n_o;
    logic inta_n_oe;
    logic rd_pend;
    logic [31:0] seed;
    logic [7:0] exp_q[$];
    int err_count;
    int total_checks;
    int cycles;
    wire inta_n;

    assign inta_n = inta_n_oe ? inta_n_o : 1'b1; // pull-up when released

    dcis_top #(.CLK_HZ(CLK_HZ), .XTAL_HZ(XTAL_HZ), .XTAL_DIV(XTAL_DIV)) uut (
        .clock, .rstn, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .port_a_side_request(a_req), .port_b_side_request(b_req),
        .group_handshake_mode(hs_mode), .inta_n_i(inta_n), .inta_n_o,
        .inta_n_oe
    );
    dcis_host_model host (
        .clock, .reg_sel, .reg_wr, .reg_rd, .reg_addr, .reg_wdata
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // a hang ends the run long after the last scenario should be done
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // read data lands one edge after the read is taken
    always @(posedge clock) rd_pend <= reg_sel && reg_rd && !reg_wr;
    always @(negedge clock) begin
        if (rd_pend && exp_q.size() > 0) begin
            cmp_byte("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    // xorshift from a fixed start of 73514
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic irq_exp(input logic [7:0] en,
                                     input logic [3:0] a, b, m);
        logic [7:0] live;
        for (int g = 0; g < 4; g++) begin
            live[2*g] = a[g] & m[g];
            live[2*g+1] = b[g] & m[g];
        end
        return |(live & en);
    endfunction

    task automatic cmp_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_pin(input logic exp);
        total_checks++;
        if (inta_n !== exp) begin
            err_count++;
            $display("BAD inta_n expected %b seen %b", exp, inta_n);
        end
    endtask

    task automatic cmp_span(input int lo, input int hi, input int seen);
        total_checks++;
        if (seen < lo || seen > hi) begin
            err_count++;
            $display("BAD span expected %0d..%0d seen %0d", lo, hi, seen);
        end
    endtask

    task automatic rd_exp(input logic [4:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        host.cycle(1'b0, addr, 8'h00);
    endtask

    task automatic drive_ports(input logic [3:0] a, b, m);
        @(posedge clock);
        a_req <= a;
        b_req <= b;
        hs_mode <= m;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    // bounded wait for a pin level; the count is the cycles it took
    task automatic wait_pin(input logic lvl, input int max, output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (inta_n !== lvl && n < max);
        cmp_pin(lvl);
    endtask

    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        logic [3:0] g;
        int n;
        rstn = 1'b0;
        a_req = 4'h0;
        b_req = 4'h0;
        hs_mode = 4'h0;
        seed = 32'h0001_1f2a;
        do_reset();
        rd_exp(`DCIS_OFS_CTR_MODE, 8'h00);
        rd_exp(`DCIS_OFS_CTR_IRQ, 8'h00);
        cmp_pin(1'b1);
        host.cycle(1'b1, 5'h12, 8'h5a);
        rd_exp(5'h12, 8'h00);
        // each line alone, then its group taken out of handshake mode
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h04);
        for (int i = 0; i < 8; i++) begin
            g = 4'h1 << (i / 2);
            host.cycle(1'b1, `DCIS_OFS_PORT_EN, 8'h01 << i);
            drive_ports(i[0] ? 4'h0 : g, i[0] ? g : 4'h0, g);
            cmp_pin(1'b0);
            drive_ports(4'hf, 4'hf, ~g);
            cmp_pin(1'b1);
        end
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'hfb);
        host.cycle(1'b1, `DCIS_OFS_PORT_EN, 8'hff);
        drive_ports(4'hf, 4'hf, 4'hf);
        cmp_pin(1'b1);
        rd_exp(`DCIS_OFS_CTR_IRQ, 8'h03);
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h04);
        for (int k = 0; k < 12; k++) begin
            r = xs();
            host.cycle(1'b1, `DCIS_OFS_PORT_EN, r[7:0]);
            rd_exp(`DCIS_OFS_PORT_EN, r[7:0]);
            drive_ports(r[11:8], r[15:12], r[19:16]);
            cmp_pin(!irq_exp(r[7:0], r[11:8], r[15:12], r[19:16]));
        end
        drive_ports(4'h0, 4'h0, 4'h0);
        do_reset();
        rd_exp(`DCIS_OFS_PORT_EN, 8'h00);
        // counter one alone: gated off, then timed to terminal count
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h04);
        host.load_ctr(1'b0, 3'h0, 16'h0014);
        repeat (60) @(negedge clock);
        cmp_pin(1'b1);
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h06);
        wait_pin(1'b0, 8, n);
        host.load_ctr(1'b0, 3'h0, 16'h0014);
        wait_pin(1'b1, 8, n);
        wait_pin(1'b0, 200, n);
        cmp_span(20 * TICK, 23 * TICK + 6, n);
        // counter one as rate prescaler for counter two
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h04);
        host.load_ctr(1'b0, 3'h2, 16'h0004);
        host.load_ctr(1'b1, 3'h0, 16'h0005);
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h07);
        repeat (2) @(negedge clock);
        cmp_pin(1'b1);
        wait_pin(1'b0, 200, n);
        cmp_span(20, 8 * 4 * TICK, n);
        // only the selected counter may reach the pin
        host.load_ctr(1'b1, 3'h0, 16'h1000);
        host.load_ctr(1'b0, 3'h0, 16'h0003);
        repeat (40) @(negedge clock);
        cmp_pin(1'b1);
        host.cycle(1'b1, `DCIS_OFS_CTR_IRQ, 8'h06);
        wait_pin(1'b0, 8, n);
        rd_exp(`DCIS_OFS_CTR_MODE, 8'h30);
        repeat (3) @(negedge clock);
        tally_and_finish();
    end
endmodule
